//--- hw/dbgfz_cfg.svh
// Constants for the debug freeze and low-power clock configuration block
`ifndef DBGFZ_CFG_SVH
`define DBGFZ_CFG_SVH

// ****************************************************************
// Register address and reset value
// ****************************************************************
`define DBGFZ_CSR_ADDR          12'h7C0
`define DBGFZ_CFG_RESET         32'h00000000

// ****************************************************************
// Field positions
// ****************************************************************
`define DBGFZ_BIT_SLEEP         0
`define DBGFZ_BIT_STOP          1
`define DBGFZ_BIT_STANDBY       2
`define DBGFZ_BIT_INDEPENDENT_WATCHDOG_FRZ      8
`define DBGFZ_BIT_WINDOWED_WATCHDOG_FRZ      9
`define DBGFZ_BIT_TIMA_FRZ      12
`define DBGFZ_BIT_TIMB_FRZ      13
`define DBGFZ_BIT_TIMC_FRZ      14

// ****************************************************************
// Timing
// ****************************************************************
`define DBGFZ_CLK_MHZ           50
`define DBGFZ_NUM_CNT           5

`endif

//--- hw/dbgfz_pkg.sv
// Types for the debug freeze and low-power clock configuration block
package dbgfz_pkg;

  typedef enum logic [1:0] {
    DBGFZ_RUN,
    DBGFZ_SLEEP,
    DBGFZ_STOP,
    DBGFZ_STANDBY
  } dbgfz_pmode_t;

  typedef enum logic [1:0] {
    DBGFZ_SRC_SYS,
    DBGFZ_SRC_IRC,
    DBGFZ_SRC_OFF
  } dbgfz_hsrc_t;

endpackage

//--- hw/dbgfz_ctl_if.sv
// Interface carrying configuration and power state between block parts
`timescale 1ns/10ps
interface dbgfz_ctl_if;
  import dbgfz_pkg::*;
  logic [31:0]  cfg;
  logic         debug_halted;
  logic [4:0]   cnt_en_in;
  logic [4:0]   cnt_en_out;
  dbgfz_pmode_t pmode;
  logic         hclk_en;
  logic         digital_pwr_on;
  dbgfz_hsrc_t  hclk_src;
  logic         clk_cfg_reset;

  modport top  (output cfg, debug_halted, cnt_en_in, pmode,
                input  cnt_en_out, hclk_en, digital_pwr_on, hclk_src, clk_cfg_reset);
  modport frz  (input cfg, debug_halted, cnt_en_in, output cnt_en_out);
  modport pwr  (input cfg, pmode, output hclk_en, digital_pwr_on, hclk_src, clk_cfg_reset);
endinterface

//--- hw/dbgfz_freeze.sv
// Per-counter debug freeze gating of increment enables
`timescale 1ns/10ps
`include "dbgfz_cfg.svh"
module dbgfz_freeze
  import dbgfz_pkg::*;
#(
  parameter int NUM_CNT = `DBGFZ_NUM_CNT
)(
  dbgfz_ctl_if.frz c
);
  localparam int FRZ_POS [0:4] = '{`DBGFZ_BIT_TIMC_FRZ, `DBGFZ_BIT_TIMB_FRZ, `DBGFZ_BIT_TIMA_FRZ,
                                   `DBGFZ_BIT_WINDOWED_WATCHDOG_FRZ, `DBGFZ_BIT_INDEPENDENT_WATCHDOG_FRZ};

  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g = g + 1)
    begin : g_frz
      assign c.cnt_en_out[g] = c.cnt_en_in[g] & ~(c.debug_halted & c.cfg[FRZ_POS[g]]);
    end
  endgenerate
endmodule // dbgfz_freeze

//--- hw/dbgfz_power.sv
// Bus clock and power decisions for sleep, stop and standby
`timescale 1ns/10ps
`include "dbgfz_cfg.svh"
module dbgfz_power
  import dbgfz_pkg::*;
(
  dbgfz_ctl_if.pwr c
);
  always_comb
  begin
    c.hclk_en        = 1'b1;
    c.digital_pwr_on = 1'b1;
    c.hclk_src       = DBGFZ_SRC_SYS;
    case (c.pmode)
      DBGFZ_RUN:
      begin
        c.hclk_en = 1'b1;
      end
      DBGFZ_SLEEP:
      begin
        c.hclk_en  = c.cfg[`DBGFZ_BIT_SLEEP];
        c.hclk_src = c.cfg[`DBGFZ_BIT_SLEEP] ? DBGFZ_SRC_SYS : DBGFZ_SRC_OFF;
      end
      DBGFZ_STOP:
      begin
        c.hclk_en  = c.cfg[`DBGFZ_BIT_STOP];
        c.hclk_src = c.cfg[`DBGFZ_BIT_STOP] ? DBGFZ_SRC_IRC : DBGFZ_SRC_OFF;
      end
      DBGFZ_STANDBY:
      begin
        c.digital_pwr_on = c.cfg[`DBGFZ_BIT_STANDBY];
        c.hclk_en        = c.cfg[`DBGFZ_BIT_STANDBY];
        c.hclk_src       = c.cfg[`DBGFZ_BIT_STANDBY] ? DBGFZ_SRC_IRC : DBGFZ_SRC_OFF;
      end
      default:
      begin
        c.hclk_en = 1'b1;
      end
    endcase
  end

  // Stop residency; a wake from here returns the clock tree to reset state
  assign c.clk_cfg_reset = (c.pmode == DBGFZ_STOP);
endmodule // dbgfz_power

//--- hw/dbgfz_top.sv
// Debug freeze and low-power bus clock configuration register, top level
`timescale 1ns/10ps
`include "dbgfz_cfg.svh"
module dbgfz_top
  import dbgfz_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        CSR_WE,
  input  wire logic        CSR_RE,
  input  wire logic [11:0] CSR_ADDR,
  input  wire logic [31:0] CSR_WDATA,
  output logic      [31:0] CSR_RDATA,
  output logic             CSR_HIT,
  input  wire logic        DEBUG_HALTED,
  input  wire logic        TIMC_INC_REQ,
  input  wire logic        TIMB_INC_REQ,
  input  wire logic        TIMA_INC_REQ,
  input  wire logic        WINDOWED_WATCHDOG_INC_REQ,
  input  wire logic        INDEPENDENT_WATCHDOG_INC_REQ,
  output logic             TIMC_INC_EN,
  output logic             TIMB_INC_EN,
  output logic             TIMA_INC_EN,
  output logic             WINDOWED_WATCHDOG_INC_EN,
  output logic             INDEPENDENT_WATCHDOG_INC_EN,
  input  wire logic        SLEEP_REQ,
  input  wire logic        STOP_REQ,
  input  wire logic        STANDBY_REQ,
  input  wire logic        WAKE,
  output logic             HCLK_EN,
  output logic             DIGITAL_PWR_ON,
  output logic [1:0]       HCLK_SRC,
  output logic             CLK_CFG_RESET,
  output logic             STANDBY_RESET,
  output logic             STANDBY_EXIT_FLAG
);

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  dbgfz_ctl_if c ();
  logic [31:0]  cfg_r;
  dbgfz_pmode_t pmode_r;
  dbgfz_pmode_t pmode_nxt;
  logic         addr_hit;

  assign addr_hit = (CSR_ADDR == `DBGFZ_CSR_ADDR);

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      cfg_r <= `DBGFZ_CFG_RESET;
    else if (CSR_WE && addr_hit)
      cfg_r <= CSR_WDATA;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      CSR_RDATA <= 32'h00000000;
      CSR_HIT   <= 1'b0;
    end
    else
    begin
      CSR_HIT   <= (CSR_RE || CSR_WE) && addr_hit;
      CSR_RDATA <= (CSR_RE && addr_hit) ? cfg_r : 32'h00000000;
    end
  end

  // ****************************************************************
  // Power mode tracking
  // ****************************************************************
  always_comb
  begin
    pmode_nxt = pmode_r;
    case (pmode_r)
      DBGFZ_RUN:
      begin
        if (STANDBY_REQ)
          pmode_nxt = DBGFZ_STANDBY;
        else if (STOP_REQ)
          pmode_nxt = DBGFZ_STOP;
        else if (SLEEP_REQ)
          pmode_nxt = DBGFZ_SLEEP;
      end
      DBGFZ_SLEEP, DBGFZ_STOP, DBGFZ_STANDBY:
      begin
        if (WAKE)
          pmode_nxt = DBGFZ_RUN;
      end
      default:
      begin
        pmode_nxt = DBGFZ_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      pmode_r <= DBGFZ_RUN;
    else
      pmode_r <= pmode_nxt;
  end

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  assign c.cfg          = cfg_r;
  assign c.debug_halted = DEBUG_HALTED;
  assign c.cnt_en_in    = {INDEPENDENT_WATCHDOG_INC_REQ, WINDOWED_WATCHDOG_INC_REQ, TIMA_INC_REQ, TIMB_INC_REQ, TIMC_INC_REQ};
  assign c.pmode        = pmode_r;

  dbgfz_freeze #(.NUM_CNT(`DBGFZ_NUM_CNT)) u_freeze (.c(c));
  dbgfz_power u_power (.c(c));

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      TIMC_INC_EN <= 1'b0;
      TIMB_INC_EN <= 1'b0;
      TIMA_INC_EN <= 1'b0;
      WINDOWED_WATCHDOG_INC_EN <= 1'b0;
      INDEPENDENT_WATCHDOG_INC_EN <= 1'b0;
    end
    else
    begin
      TIMC_INC_EN <= c.cnt_en_out[0];
      TIMB_INC_EN <= c.cnt_en_out[1];
      TIMA_INC_EN <= c.cnt_en_out[2];
      WINDOWED_WATCHDOG_INC_EN <= c.cnt_en_out[3];
      INDEPENDENT_WATCHDOG_INC_EN <= c.cnt_en_out[4];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      HCLK_EN        <= 1'b1;
      DIGITAL_PWR_ON <= 1'b1;
      HCLK_SRC       <= 2'h0;
    end
    else
    begin
      HCLK_EN        <= c.hclk_en;
      DIGITAL_PWR_ON <= c.digital_pwr_on;
      HCLK_SRC       <= c.hclk_src;
    end
  end

  // Exit events: stop exit restores reset clocks, standby exit is a system reset
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      CLK_CFG_RESET <= 1'b0;
      STANDBY_RESET <= 1'b0;
    end
    else
    begin
      CLK_CFG_RESET <= c.clk_cfg_reset && WAKE;
      STANDBY_RESET <= (pmode_r == DBGFZ_STANDBY) && WAKE;
    end
  end

  // Standby-exit status survives the system reset it causes, so RSTN leaves it alone
  // Undefined after power-up until software writes the register or a standby exit sets it; set wins over clear
  always_ff @(posedge CLK)
  begin
    if ((pmode_r == DBGFZ_STANDBY) && WAKE)
      STANDBY_EXIT_FLAG <= 1'b1;
    else if (RSTN && CSR_WE && addr_hit)
      STANDBY_EXIT_FLAG <= 1'b0;
  end

endmodule // dbgfz_top

//--- verif/dbgfz_assertions.sv
// Port checks for the debug freeze configuration block
`timescale 1ns/10ps
module dbgfz_checker (
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        CSR_WE,
  input wire logic        CSR_RE,
  input wire logic [11:0] CSR_ADDR,
  input wire logic [31:0] CSR_WDATA,
  input wire logic [31:0] CSR_RDATA,
  input wire logic        CSR_HIT,
  input wire logic        DEBUG_HALTED,
  input wire logic        TIMC_INC_REQ,
  input wire logic        TIMB_INC_REQ,
  input wire logic        TIMA_INC_REQ,
  input wire logic        WINDOWED_WATCHDOG_INC_REQ,
  input wire logic        INDEPENDENT_WATCHDOG_INC_REQ,
  input wire logic        TIMC_INC_EN,
  input wire logic        TIMB_INC_EN,
  input wire logic        TIMA_INC_EN,
  input wire logic        WINDOWED_WATCHDOG_INC_EN,
  input wire logic        INDEPENDENT_WATCHDOG_INC_EN,
  input wire logic        DIGITAL_PWR_ON,
  input wire logic        STANDBY_RESET
);
  logic [31:0] shad_r;
  wire         hit_req = (CSR_WE || CSR_RE) && CSR_ADDR == 12'h7C0;
  // Shadow of the register, rebuilt from the write strobes
  always_ff @(posedge CLK)
    if (!RSTN)
      shad_r <= 32'h0;
    else if (CSR_WE && CSR_ADDR == 12'h7C0)
      shad_r <= CSR_WDATA;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property frz_p(en, req, b);
    1'b1 |=> en == $past(req && !(DEBUG_HALTED && b));
  endproperty
  csr_hit_a: assert property (hit_req |=> CSR_HIT)
    else $error("no hit");
  csr_miss_a: assert property ((CSR_WE || CSR_RE) && !hit_req |=> !CSR_HIT && CSR_RDATA == 32'h0)
    else $error("miss answered");
  csr_read_a: assert property (CSR_RE && hit_req |=> CSR_RDATA == $past(shad_r))
    else $error("read data");
  timc_gate_a: assert property (frz_p(TIMC_INC_EN, TIMC_INC_REQ, shad_r[14]))
    else $error("timer c gate");
  timb_gate_a: assert property (frz_p(TIMB_INC_EN, TIMB_INC_REQ, shad_r[13]))
    else $error("timer b gate");
  tima_gate_a: assert property (frz_p(TIMA_INC_EN, TIMA_INC_REQ, shad_r[12]))
    else $error("timer a gate");
  windowed_watchdog_gate_a: assert property (frz_p(WINDOWED_WATCHDOG_INC_EN, WINDOWED_WATCHDOG_INC_REQ, shad_r[9]))
    else $error("windowed gate");
  independent_watchdog_gate_a: assert property (frz_p(INDEPENDENT_WATCHDOG_INC_EN, INDEPENDENT_WATCHDOG_INC_REQ, shad_r[8]))
    else $error("independent gate");
  pwr_off_a: assert property (!DIGITAL_PWR_ON |-> !shad_r[2])
    else $error("power off");
  sby_pulse_a: assert property (STANDBY_RESET |=> !STANDBY_RESET)
    else $error("standby pulse");
  cover property (hit_req && CSR_WE);
  cover property (DEBUG_HALTED && shad_r[14] && TIMC_INC_REQ);
  cover property (STANDBY_RESET);
endmodule // dbgfz_checker
bind dbgfz_top dbgfz_checker i_chk (.*);

//--- verif/dbgfz_far.sv
// Counter side model: raises increment requests and counts granted ticks
`timescale 1ns/10ps
module dbgfz_far (
  input  wire logic      clk,
  input  wire logic      rstn,
  input  wire logic      run,
  input  wire logic [4:0] en,
  output logic      [4:0] req,
  output logic [4:0][7:0] cnt
);
  assign req = {5{run}};
  always_ff @(posedge clk)
    for (int i = 0; i < 5; i++)
      cnt[i] <= rstn ? cnt[i] + 8'(en[i]) : 8'h00;
endmodule // dbgfz_far

//--- verif/testbench.sv
// Self-checking bench for the debug freeze configuration block
`timescale 1ns/10ps
module testbench;
  logic            clk, rstn, we, re, halted, run, wake, saw_ccr, saw_sr;
  logic            hit, hclk_en, pwr_on, cfg_rst, sby_rst, sby_flag;
  logic [11:0]     addr;
  logic [31:0]     wdata, rdata;
  logic [1:0]      hclk_src;
  logic [2:0]      lp_req;
  logic [4:0]      req, en;
  logic [4:0][7:0] cnt;
  logic [7:0]      c0, c1;
  int              mismatches, cmp_count, cyc;
  int              fb[5] = '{8, 9, 12, 13, 14};
  dbgfz_top i_dut (.CLK(clk), .RSTN(rstn), .CSR_WE(we), .CSR_RE(re), .CSR_ADDR(addr), .CSR_WDATA(wdata),
    .CSR_RDATA(rdata), .CSR_HIT(hit), .DEBUG_HALTED(halted), .TIMC_INC_REQ(req[4]), .TIMB_INC_REQ(req[3]),
    .TIMA_INC_REQ(req[2]), .WINDOWED_WATCHDOG_INC_REQ(req[1]), .INDEPENDENT_WATCHDOG_INC_REQ(req[0]), .TIMC_INC_EN(en[4]),
    .TIMB_INC_EN(en[3]), .TIMA_INC_EN(en[2]), .WINDOWED_WATCHDOG_INC_EN(en[1]), .INDEPENDENT_WATCHDOG_INC_EN(en[0]),
    .SLEEP_REQ(lp_req[0]), .STOP_REQ(lp_req[1]), .STANDBY_REQ(lp_req[2]), .WAKE(wake), .HCLK_EN(hclk_en),
    .DIGITAL_PWR_ON(pwr_on), .HCLK_SRC(hclk_src), .CLK_CFG_RESET(cfg_rst), .STANDBY_RESET(sby_rst),
    .STANDBY_EXIT_FLAG(sby_flag));
  dbgfz_far i_far (.clk(clk), .rstn(rstn), .run(run), .en(en), .req(req), .cnt(cnt));
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // One register access; answer sampled after its taking edge
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    we <= w;
    re <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 0;
    re <= 0;
    #1;
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cfg_rst)
      saw_ccr <= 1;
    if (sby_rst)
      saw_sr <= 1;
    if (cyc == 3000)
    begin
      mismatches++;
      end_sim;
    end
  end
  initial
  begin
    {rstn, we, re, halted, run, wake, saw_ccr, saw_sr, addr, wdata, lp_req} = '0;
    repeat (4) @(posedge clk);
    rstn <= 1;
    acc(0, 12'h7C0, 0);
    chk("cfg reset", 0, rdata);
    acc(1, 12'h7C0, 32'hFFFFFFFF);
    chk("hit", 1, hit);
    chk("exit flag clear", 0, sby_flag);
    acc(1, 12'h7C1, 0);
    chk("miss hit", 0, hit);
    acc(0, 12'h7C0, 0);
    chk("cfg all ones", 32'hFFFFFFFF, rdata);
    @(posedge clk);
    run <= 1;
    halted <= 1;
    for (int k = 0; k < 5; k++)
    begin
      acc(1, 12'h7C0, 32'h1 << fb[k]);
      edges(2);
      chk("enables", 5'h1F & ~(5'h1 << k), en);
      c0 = cnt[k];
      c1 = cnt[(k + 1) % 5];
      edges(3);
      chk("frozen count", c0, cnt[k]);
      chk("running count", 8'(c1 + 8'h03), cnt[(k + 1) % 5]);
    end
    @(posedge clk);
    halted <= 0;
    edges(2);
    chk("enables run", 5'h1F, en);
    for (int m = 0; m < 3; m++)
      for (int s = 0; s < 2; s++)
      begin
        acc(1, 12'h7C0, 32'(s) << m);
        @(posedge clk);
        lp_req[m] <= 1;
        @(posedge clk);
        lp_req[m] <= 0;
        edges(3);
        chk("hclk_en", s, hclk_en);
        chk("hclk_src", s ? (m == 0 ? 2'h0 : 2'h1) : 2'h2, hclk_src);
        chk("pwr_on", m != 2 || s, pwr_on);
        saw_ccr = 0;
        saw_sr = 0;
        @(posedge clk);
        wake <= 1;
        @(posedge clk);
        wake <= 0;
        edges(3);
        chk("stop exit", m == 1, saw_ccr);
        chk("standby exit", m == 2, saw_sr);
        chk("hclk woken", 1, hclk_en);
        if (m == 1)
          acc(1, 12'h7C0, 32'h00000000);
        if (m == 2)
        begin
          @(posedge clk);
          rstn <= 0;
          @(posedge clk);
          rstn <= 1;
          acc(0, 12'h7C0, 0);
          chk("cfg after exit", 0, rdata);
          chk("exit flag", 1, sby_flag);
        end
      end
    end_sim;
  end
endmodule // testbench
